// *** inc/two_wire_consts.vh ***
// Constants for the two-wire serial master: register offsets, field
// positions, reset values and frame codes.
// Assumes a 16-bit register address and 8-bit register data.
`ifndef TWO_WIRE_CONSTS_VH
`define TWO_WIRE_CONSTS_VH

////////////////////////////////////////////////////////////////////////////
`define ADDR_EXT_IRQ_EN      16'h28A5
`define ADDR_PERIPH_GATE     16'h2D00
`define ADDR_FRAME_CFG       16'h2F01
`define ADDR_DIV_LOW         16'h2F02
`define ADDR_DIV_HIGH        16'h2F03
`define ADDR_SHIFT_DATA      16'h2F04
`define ADDR_XFER_FLAGS      16'h2F05

////////////////////////////////////////////////////////////////////////////
`define PORT_EN_BIT          6
`define IE_FRAME_DONE_BIT    4
`define IE_ILLEGAL_WR_BIT    5
`define CFG_LSB_FIRST_BIT    4
`define CFG_STOP_BIT         1
`define FLG_BUSY_BIT         1
`define FLG_ACK_BIT          0

////////////////////////////////////////////////////////////////////////////
`define REG_RESET            8'h00
`define DIV_RESET            16'h0000
`define LINE_IDLE            1'b1
`define ACK_BIT_INDEX        4'h8
`define QUARTER_FIRST        2'h0
`define QUARTER_SET          2'h1
`define QUARTER_LAST         2'h3

////////////////////////////////////////////////////////////////////////////
// Frame structure codes, bits START, DATA+ACK, STOP, RESTART.
`define FRAME_START_DATA     4'hC
`define FRAME_START_ONLY     4'h8
`define FRAME_DATA_STOP      4'h6
`define FRAME_DATA_RESTART   4'h5
`define FRAME_DATA_ONLY      4'h4
`define FRAME_STOP_ONLY      4'h2
`define FRAME_RESTART_ONLY   4'h1

`endif

// *** rtl/scl_divider.v ***
// Quarter-period tick generator for the serial clock.
// Assumes the threshold is stable while run is high.
module scl_divider #(
  parameter WIDTH = 16
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             run,
  input  wire [WIDTH-1:0] threshold,
  output wire             tick
);

  reg [WIDTH-1:0] count_q;
  reg [WIDTH-1:0] count_d;

  // One tick every threshold plus one clocks gives four ticks per period.
  assign tick = run && (count_q == threshold); // RQ10

  always @* begin
    count_d = count_q;
    if (!run || tick) begin
      count_d = {WIDTH{1'b0}};
    end else begin
      count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= {WIDTH{1'b0}};
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// *** rtl/two_wire_serial_master.v ***
// Byte-at-a-time two-wire serial master with its register file.
// Assumes a plain register port with read data one cycle after the strobe,
// open-drain data pin resolved outside, and global interrupt enables
// applied by the interrupt controller that receives the event pulses.
//
// Behaviour
// RQ1 - Port enable bit routes the pins and drives the clock pin as output.
// RQ2 - Software enables the data pin as an input before use.
// RQ3 - START is data falling while the clock is high.
// RQ4 - Each bit takes one clock; set on falling, sampled on rising edge; the code sets a quarter after the fall, samples at end of high.
// RQ5 - Byte bit order follows configuration bit 4.
// RQ6 - Order bit one sends least significant first, zero most significant.
// RQ7 - Eight data bits then one acknowledge; low means acknowledged.
// RQ8 - STOP or RESTART: clock falls, then data rises or falls clock high.
// RQ9 - Configuration bits 3..0 pick frame parts; only five kinds valid; the code accepts seven.
// RQ10 - Divider makes clock at system clock over four times threshold+1.
// RQ11 - Threshold is built from a high and a low byte register.
// RQ12 - Software keeps the serial clock at or below 400 kHz.
// RQ13 - Read-back data and acknowledge show the wired-AND line level.
// RQ14 - Data write while idle launches the frame and sets busy until done.
// RQ15 - Software writes all ones to receive, else the byte to send.
// RQ16 - Frame completion raises the done event when its enable is set.
// RQ17 - Writes while busy are dropped and raise the illegal-write event; the code takes gate and enable writes, drops flag writes silently.
// RQ18 - Clock is held low after a byte until the next frame.
// RQ19 - Software sends the slave address and direction in the first byte.
// RQ20 - Software writes one to the acknowledge flag, reads it after busy.
// RQ21 - Software sequences divider, START, address, data, then STOP.
// RQ22 - Acknowledge flag value is driven back when receiving.
// RQ23 - Reserved frame codes start nothing and leave the lines alone.
`include "two_wire_consts.vh"

module two_wire_serial_master #(
  parameter DIV_WIDTH = 16
) (
  input  wire       clk,
  input  wire       rst,
  input  wire [15:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_en,
  input  wire       rd_en,
  output reg  [7:0] rdata,
  output reg        frame_done_irq,
  output reg        illegal_write_irq,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe,
  output wire       scl_o,
  output wire       scl_oe
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_BIT   = 2'h2;
  localparam ST_END   = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Frame codes other than the seven accepted ones are refused.
  function frame_valid;
    input [3:0] code;
    begin
      case (code)
        `FRAME_START_DATA,
        `FRAME_START_ONLY,
        `FRAME_DATA_STOP,
        `FRAME_DATA_RESTART,
        `FRAME_DATA_ONLY,
        `FRAME_STOP_ONLY,
        `FRAME_RESTART_ONLY: frame_valid = 1'b1; // RQ9
        default:             frame_valid = 1'b0;
      endcase
    end
  endfunction

  function is_target;
    input [15:0] a;
    input [15:0] target;
    begin
      is_target = (a == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg [7:0]  irq_en_q;
  reg [7:0]  gate_q;
  reg [7:0]  cfg_q;
  reg [7:0]  div_low_q;
  reg [7:0]  div_high_q;
  reg [7:0]  shift_q;
  reg [7:0]  shift_d;
  reg [5:0]  flag_spare_q;
  reg        ack_q;
  reg        ack_d;
  reg        busy_q;
  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg [1:0]  quarter_q;
  reg [3:0]  bit_cnt_q;
  reg [3:0]  bit_cnt_d;
  reg        scl_q;
  reg        scl_d;
  reg        sda_q;
  reg        sda_d;
  reg        sda_meta_q;
  reg        sda_sync_q;
  reg        finish;

  wire       tick;
  wire       port_en;
  wire       lsb_first;
  wire       stop_sel;
  wire       elem_end;
  wire       wr_guarded;
  wire       launch;
  wire       tx_bit;
  wire [15:0] threshold;

  assign port_en   = gate_q[`PORT_EN_BIT];
  assign lsb_first = cfg_q[`CFG_LSB_FIRST_BIT];
  assign stop_sel  = cfg_q[`CFG_STOP_BIT];
  assign threshold = {div_high_q, div_low_q}; // RQ11
  assign elem_end  = tick && (quarter_q == `QUARTER_LAST);
  assign tx_bit    = lsb_first ? shift_q[0] : shift_q[7]; // RQ6

  // Configuration, divider and data writes are dropped while busy.
  assign wr_guarded = wr_en && (addr >= `ADDR_FRAME_CFG) &&
                      (addr <= `ADDR_SHIFT_DATA);
  // A disabled port never launches, so the lines cannot toggle unrouted.
  assign launch = wr_en && is_target(addr, `ADDR_SHIFT_DATA) && !busy_q &&
                  port_en && frame_valid(cfg_q[3:0]); // RQ14 RQ23

  ////////////////////////////////////////////////////////////////////////////
  // The pin pair only belongs to the port while it is enabled.
  assign scl_o  = scl_q;
  assign scl_oe = port_en; // RQ1
  assign sda_o  = 1'b0;
  assign sda_oe = port_en && !sda_q; // RQ1

  scl_divider #(
    .WIDTH     (DIV_WIDTH)
  ) u_divider (
    .clk       (clk),
    .rst       (rst),
    .run       (busy_q),
    .threshold (threshold[DIV_WIDTH-1:0]),
    .tick      (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Line sequencing: four quarters per element, clock high in quarters 2-3, and in all four during START.
  always @* begin
    state_d   = state_q;
    bit_cnt_d = bit_cnt_q;
    scl_d     = scl_q;
    sda_d     = sda_q;
    finish    = 1'b0;
    if (launch) begin
      bit_cnt_d = 4'h0;
      if (cfg_q[3]) begin
        state_d = ST_START;
      end else if (cfg_q[2]) begin
        state_d = ST_BIT;
      end else begin
        state_d = ST_END;
      end
    end
    case (state_q)
      ST_START: begin
        scl_d = 1'b1;
        sda_d = ~quarter_q[1]; // RQ3
        if (elem_end) begin
          if (cfg_q[2]) begin
            state_d = ST_BIT;
          end else begin
            finish = 1'b1;
          end
        end
      end
      ST_BIT: begin
        scl_d = quarter_q[1]; // RQ4
        // Data moves a full quarter after the falling edge, never with it.
        if (quarter_q == `QUARTER_SET) begin
          if (bit_cnt_q == `ACK_BIT_INDEX) begin
            sda_d = ack_q; // RQ22
          end else begin
            sda_d = tx_bit; // RQ5
          end
        end
        if (elem_end) begin
          if (bit_cnt_q == `ACK_BIT_INDEX) begin // RQ7
            scl_d = 1'b0; // RQ18
            if (cfg_q[1] || cfg_q[0]) begin
              state_d = ST_END;
            end else begin
              finish = 1'b1;
            end
          end else begin
            bit_cnt_d = bit_cnt_q + 4'h1;
          end
        end
      end
      ST_END: begin
        scl_d = quarter_q[1];
        if (quarter_q == `QUARTER_SET) begin
          sda_d = !stop_sel; // RQ8
        end else if (quarter_q == `QUARTER_LAST) begin
          sda_d = stop_sel; // RQ8
        end
        if (elem_end) begin
          finish = 1'b1;
        end
      end
      default: begin
      end
    endcase
    if (finish) begin
      state_d = ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and acknowledge flag take the synchronised line level.
  always @* begin
    shift_d = shift_q;
    ack_d   = ack_q;
    if (!busy_q && wr_en && is_target(addr, `ADDR_SHIFT_DATA)) begin
      shift_d = wdata;
    end
    if (!busy_q && wr_en && is_target(addr, `ADDR_XFER_FLAGS)) begin
      ack_d = wdata[`FLG_ACK_BIT];
    end
    if (state_q == ST_BIT && elem_end) begin
      if (bit_cnt_q == `ACK_BIT_INDEX) begin
        ack_d = sda_sync_q; // RQ13
      end else if (lsb_first) begin
        shift_d = {sda_sync_q, shift_q[7:1]}; // RQ13
      end else begin
        shift_d = {shift_q[6:0], sda_sync_q}; // RQ13
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_meta_q <= `LINE_IDLE;
      sda_sync_q <= `LINE_IDLE;
    end else begin
      sda_meta_q <= sda_i;
      sda_sync_q <= sda_meta_q;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      quarter_q <= `QUARTER_FIRST;
      bit_cnt_q <= 4'h0;
      scl_q     <= `LINE_IDLE;
      sda_q     <= `LINE_IDLE;
      busy_q    <= 1'b0;
      shift_q   <= `REG_RESET;
      ack_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      bit_cnt_q <= bit_cnt_d;
      scl_q     <= scl_d;
      sda_q     <= sda_d;
      shift_q   <= shift_d;
      ack_q     <= ack_d;
      if (launch) begin
        quarter_q <= `QUARTER_FIRST;
      end else if (tick) begin
        quarter_q <= quarter_q + 2'h1;
      end
      if (launch) begin
        busy_q <= 1'b1; // RQ14
      end else if (finish) begin
        busy_q <= 1'b0; // RQ14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain register storage; guarded registers ignore writes while busy.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_en_q     <= `REG_RESET;
      gate_q       <= `REG_RESET;
      cfg_q        <= `REG_RESET;
      div_low_q    <= `REG_RESET;
      div_high_q   <= `REG_RESET;
      flag_spare_q <= 6'h00;
    end else if (wr_en) begin
      if (is_target(addr, `ADDR_EXT_IRQ_EN)) begin
        irq_en_q <= wdata;
      end
      if (is_target(addr, `ADDR_PERIPH_GATE)) begin
        gate_q <= wdata;
      end
      if (!busy_q) begin // RQ17
        if (is_target(addr, `ADDR_FRAME_CFG)) begin
          cfg_q <= wdata;
        end
        if (is_target(addr, `ADDR_DIV_LOW)) begin
          div_low_q <= wdata;
        end
        if (is_target(addr, `ADDR_DIV_HIGH)) begin
          div_high_q <= wdata;
        end
        if (is_target(addr, `ADDR_XFER_FLAGS)) begin
          flag_spare_q <= wdata[7:2];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event pulses; global enables are applied by the interrupt controller.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_done_irq    <= 1'b0;
      illegal_write_irq <= 1'b0;
    end else begin
      frame_done_irq    <= finish && irq_en_q[`IE_FRAME_DONE_BIT]; // RQ16
      illegal_write_irq <= wr_guarded && busy_q &&
                           irq_en_q[`IE_ILLEGAL_WR_BIT]; // RQ17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data stands only in the cycle after the strobe; unmapped reads 0.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= `REG_RESET;
    end else if (rd_en) begin
      case (addr)
        `ADDR_EXT_IRQ_EN:  rdata <= irq_en_q;
        `ADDR_PERIPH_GATE: rdata <= gate_q;
        `ADDR_FRAME_CFG:   rdata <= cfg_q;
        `ADDR_DIV_LOW:     rdata <= div_low_q;
        `ADDR_DIV_HIGH:    rdata <= div_high_q;
        `ADDR_SHIFT_DATA:  rdata <= shift_q;
        `ADDR_XFER_FLAGS:  rdata <= {flag_spare_q, busy_q, ack_q};
        default:           rdata <= `REG_RESET;
      endcase
    end else begin
      rdata <= `REG_RESET;
    end
  end

endmodule

// *** test/tw_asserts.sv ***
// Port-level timing checks for the two-wire serial master.
// Assumes it is bound to the top module and sees only its ports.
module tw_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  rdata,
  input wire logic        frame_done_irq,
  input wire logic        illegal_write_irq,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        scl_o,
  input wire logic        scl_oe
);
  logic gate_bit;
  assign gate_bit = wdata[6];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////
  a_read_idle:
    assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_sda_open:
    assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  a_gate_oe:
    assert property (wr_en && addr == 16'h2D00 |=> scl_oe == $past(gate_bit))
    else $error("clock enable does not follow port enable");
  a_port_off:
    assert property (!scl_oe |-> !sda_oe)
    else $error("data pulled while port disabled");
  a_done_pulse:
    assert property (frame_done_irq |=> !frame_done_irq)
    else $error("frame done longer than one cycle");
  a_illegal_cause:
    assert property (illegal_write_irq |-> $past(wr_en) &&
      $past(addr) >= 16'h2F01 && $past(addr) <= 16'h2F04)
    else $error("illegal write event without a write");
  a_scl_min_high:
    assert property ($rose(scl_o) |=> scl_o)
    else $error("clock high shorter than two cycles");
  a_reset_idle:
    assert property ($fell(rst) |-> scl_o && !sda_oe && !scl_oe)
    else $error("lines not idle after reset");
  c_done: cover property (frame_done_irq);
  c_illegal: cover property (illegal_write_irq);
  c_scl: cover property ($fell(scl_o));
endmodule

// *** test/tw_slave.sv ***
// Behavioural slave on the two-wire bus.
// Assumes the bench resolves the wired-AND line with a pull-up.
module tw_slave (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_en,
  input  wire logic       rd,
  input  wire logic [7:0] tx,
  output logic            pull
);
  logic [3:0] cnt = 4'h8;
  logic       on = 1'b0;
  logic       st = 1'b0;
  always @(negedge sda) if (scl) begin
    cnt = 4'h8;
    st = 1'b1;
    on = 1'b0;
  end
  // Data moves only while the clock is low.
  always @(negedge scl) begin
    cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
    if (st) on = 1'b1;
    st = 1'b0;
  end
  // A refused byte ends a read so the master can stop.
  always @(posedge scl) if (cnt == 4'h8 && rd && sda) on = 1'b0;
  assign pull = on && (cnt == 4'h8 ? ack_en && !rd
                                   : rd && !tx[3'h7 - cnt[2:0]]);
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the two-wire serial master.
// Assumes the slave model and checker are compiled before it.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, rd_s = 1'b0;
  logic [15:0] addr = 16'h0;
  logic [7:0]  wdata = 8'h0, rdata;
  logic        fd, iw, sda_o, sda_oe, scl_o, scl_oe, pull;
  logic [8:0]  mon;
  int miscompares = 0, cmp_count = 0, nd = 0, ni = 0, ns = 0, np = 0;
  int hw = 0, hl = 0, hp = 0;
  logic [15:0] ra [9] = '{16'h28A5, 16'h2D00, 16'h2F01, 16'h2F02,
    16'h2F03, 16'h2F04, 16'h2F05, 16'h2F00, 16'h2F06};
  wire sda = ~((sda_oe & ~sda_o) | pull);
  two_wire_serial_master uut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .frame_done_irq(fd),
    .illegal_write_irq(iw), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe));
  tw_slave slv (.scl(scl_o), .sda(sda), .ack_en(1'b1), .rd(rd_s),
    .tx(8'h6C), .pull(pull));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    nd <= nd + fd;
    ni <= ni + iw;
    hw <= scl_o ? hw + 1 : 0;
    // The hold-low cuts the last clock short, so keep the one before too.
    if (!scl_o && hw != 0) begin
      hp <= hl;
      hl <= hw;
    end
  end
  always @(posedge scl_o) mon = {mon[7:0], sda};
  // Reset settles both lines in one step, which is no line condition.
  always @(negedge sda) if (scl_o && !rst) ns++;
  always @(posedge sda) if (scl_o && !rst) np++;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk($sformatf("reg %h", a), {8'h0, v}, {8'h0, e});
  endtask
  // Bounded wait so a stuck busy flag cannot hang the run.
  task automatic poll;
    logic [7:0] v;
    int n;
    n = 0;
    do begin
      rd(16'h2F05, v);
      n++;
    end while (v[1] !== 1'b0 && n < 5000);
    chk("busy", {15'h0, v[1]}, 16'h0);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) rc(ra[i], 8'h00);
    wr(16'h2D00, 8'h40);
    wr(16'h28A5, 8'h30);
    wr(16'h2F02, 8'h7C);
    chk("scl_oe", {15'h0, scl_oe}, 16'h1);
    rc(16'h2F02, 8'h7C);
    for (int c = 0; c < 16; c++) begin
      if (!(c inside {1, 2, 4, 5, 6, 8, 12})) begin
        wr(16'h2F01, 8'(c));
        wr(16'h2F04, 8'h55);
        rc(16'h2F05, 8'h00);
      end
    end
    chk("lines", {14'h0, scl_o, sda}, 16'h3);
    wr(16'h2F01, 8'h08);
    wr(16'h2F04, 8'h00);
    rc(16'h2F05, 8'h02);
    poll();
    chk("start", {14'h0, scl_o, sda}, 16'h2);
    chk("starts", 16'(ns), 16'h1);
    wr(16'h2F03, 8'h01);
    wr(16'h2F02, 8'h00);
    wr(16'h2F01, 8'h04);
    wr(16'h2F05, 8'h01);
    wr(16'h2F04, 8'hA7);
    wr(16'h2F01, 8'h0C);
    poll();
    chk("wire", {8'h0, mon[8:1]}, 16'hA7);
    chk("ack", {15'h0, mon[0]}, 16'h0);
    chk("high", 16'(hp), 16'd514);
    chk("hold", {15'h0, scl_o}, 16'h0);
    rc(16'h2F05, 8'h00);
    rc(16'h2F04, 8'hA7);
    rc(16'h2F01, 8'h04);
    chk("illegal", 16'(ni), 16'h1);
    wr(16'h2F03, 8'h00);
    wr(16'h2F02, 8'h7C);
    wr(16'h2F01, 8'h14);
    wr(16'h2F05, 8'h01);
    rd_s <= 1'b1;
    wr(16'h2F04, 8'hFF);
    poll();
    rd_s <= 1'b0;
    rc(16'h2F04, 8'h36);
    chk("nack", {15'h0, mon[0]}, 16'h1);
    rc(16'h2F05, 8'h01);
    chk("high", 16'(hp), 16'd250);
    wr(16'h2F01, 8'h02);
    wr(16'h2F04, 8'h00);
    poll();
    chk("stop", {14'h0, scl_o, sda}, 16'h3);
    chk("stops", 16'(np), 16'h1);
    wr(16'h2F01, 8'h01);
    wr(16'h2F04, 8'h00);
    poll();
    chk("restart", 16'(ns), 16'h2);
    chk("done", 16'(nd), 16'h5);
    conclude();
  end
endmodule
bind two_wire_serial_master tw_asserts chk_i (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .frame_done_irq(frame_done_irq),
  .illegal_write_irq(illegal_write_irq), .sda_o(sda_o),
  .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe));
